/* File: ref_clock_monitor_select_pkg.sv */
package ref_clock_monitor_select_pkg;

   // ****************************************
   // register map
   // ****************************************
   localparam logic [7:0] ADDR_CONTROL = 8'h00;
   localparam logic [7:0] ADDR_PRIORITY = 8'h04;
   localparam logic [7:0] ADDR_COUNTS = 8'h08;
   localparam logic [7:0] ADDR_STATUS = 8'h0C;
   localparam logic [7:0] ADDR_LOSS = 8'h10;

   // ****************************************
   // field layout and reset values
   // ****************************************
   localparam int CTRL_WIDTH = 7;
   localparam int PRIO_WIDTH = 2;
   localparam int LOSS_REF_BIT = 4;
   localparam int REVAL_LSB = 0;
   localparam int HOLDOFF_LSB = 8;
   localparam int PRESCALE_LSB = 16;
   localparam int ST_SEL_LSB = 4;
   localparam int ST_HOLD_BIT = 6;
   localparam int ST_REFOK_BIT = 7;
   localparam int ST_LOCKEN_BIT = 8;
   localparam logic [6:0] CONTROL_RESET = 7'h40;
   localparam logic [7:0] PRIORITY_RESET = 8'h00;
   localparam logic [31:0] COUNTS_RESET = 32'h0000_0000;
   localparam logic [1:0] AXI_OKAY = 2'h0;
   localparam logic [1:0] AXI_SLVERR = 2'h2;

   // ****************************************
   // timing counts
   // ****************************************
   localparam logic [1:0] MISS_LIMIT = 2'h3;

   // ****************************************
   // types
   // ****************************************
   typedef enum logic [1:0] {
      MODE_MANUAL = 2'b00,
      MODE_AUTO = 2'b01,
      MODE_SHORT_HOLD = 2'b10,
      MODE_AUTO_HOLD = 2'b11
   } mode_type;

   typedef struct packed {
      logic los_ref_divider_powerdown;
      logic los_flag_block;
      logic revertive_enable;
      logic [1:0] manual_select;
      mode_type selection_mode;
   } ctrl_type;

   typedef struct packed {
      logic [15:0] holdoff_prescaler;
      logic [7:0] holdoff_start_value;
      logic [7:0] revalidation_count;
   } counts_type;

   typedef enum logic [2:0] {
      ST_LOCKED = 3'b001,
      ST_HOLDOVER = 3'b010,
      ST_UNLOCKED = 3'b100
   } sel_state_type;

endpackage

/* File: ref_clock_monitor_select.sv */
module ref_clock_monitor_select #(
   parameter int NUM_INPUTS = 4,
   parameter int FREQ_W = 24
) (
   input wire logic i_ref_clk,
   input wire logic i_reset,
   input wire logic [3:0] i_clk_in,
   input wire logic [3:0] i_diff_zero,
   input wire logic i_los_ref_div,
   input wire logic i_vcxo_div,
   input wire logic [FREQ_W-1:0] i_freq_word,
   output logic [1:0] o_selected_input,
   output logic o_holdover,
   output logic o_pll_lock_enable,
   output logic [FREQ_W-1:0] o_holdover_word,
   output logic o_los_ref_divider_powerdown,
   input wire logic [7:0] i_s_axi_awaddr,
   input wire logic i_s_axi_awvalid,
   output logic o_s_axi_awready,
   input wire logic [31:0] i_s_axi_wdata,
   input wire logic [3:0] i_s_axi_wstrb,
   input wire logic i_s_axi_wvalid,
   output logic o_s_axi_wready,
   output logic [1:0] o_s_axi_bresp,
   output logic o_s_axi_bvalid,
   input wire logic i_s_axi_bready,
   input wire logic [7:0] i_s_axi_araddr,
   input wire logic i_s_axi_arvalid,
   output logic o_s_axi_arready,
   output logic [31:0] o_s_axi_rdata,
   output logic [1:0] o_s_axi_rresp,
   output logic o_s_axi_rvalid,
   input wire logic i_s_axi_rready
);

   // ****************************************
   // synchronisers and edge detect
   // ****************************************
   localparam int SYNC_W = 2 * NUM_INPUTS + 2;
   logic [SYNC_W-1:0] sync1_q, sync2_q, sync3_q;
   logic [SYNC_W-1:0] pin_bus;
   assign pin_bus = {i_vcxo_div, i_los_ref_div, i_diff_zero, i_clk_in};

   always_ff @(posedge i_ref_clk or posedge i_reset) begin
      if (i_reset) begin
         sync1_q <= '0;
         sync2_q <= '0;
         sync3_q <= '0;
      end else begin
         sync1_q <= pin_bus;
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
      end
   end

   wire [NUM_INPUTS-1:0] in_rise = sync2_q[NUM_INPUTS-1:0] & ~sync3_q[NUM_INPUTS-1:0];
   wire [NUM_INPUTS-1:0] diff_zero = sync2_q[2*NUM_INPUTS-1:NUM_INPUTS];
   wire ref_rise = sync2_q[2*NUM_INPUTS] & ~sync3_q[2*NUM_INPUTS];
   wire vcxo_rise = sync2_q[2*NUM_INPUTS+1] & ~sync3_q[2*NUM_INPUTS+1];

   // ****************************************
   // registers
   // ****************************************
   ref_clock_monitor_select_pkg::ctrl_type ctrl_q;
   ref_clock_monitor_select_pkg::counts_type counts_q;
   logic [7:0] prio_q;
   logic [NUM_INPUTS-1:0] loss_latched_q;
   logic ref_loss_latched_q;
   ref_clock_monitor_select_pkg::mode_type mode;
   assign mode = ctrl_q.selection_mode;

   // ****************************************
   // per-input activity monitors
   // ****************************************
   logic [NUM_INPUTS-1:0] valid_q;
   logic [NUM_INPUTS-1:0] loss_event;
   logic [NUM_INPUTS-1:0] eff_valid;
   // a powered-down divider gives no reference edges, so no input is judged lost by missed edges, only by diff_zero
   wire ref_tick = ref_rise & ~ctrl_q.los_ref_divider_powerdown;

   genvar g;
   generate
      for (g = 0; g < NUM_INPUTS; g++) begin : g_mon
         logic [1:0] miss_q;
         logic [7:0] good_q;
         logic valid_bit_q;
         wire miss_full = (miss_q == 2'(ref_clock_monitor_select_pkg::MISS_LIMIT - 2'h1));
         wire miss_out = ref_tick & ~in_rise[g] & miss_full;
         wire lose = valid_q[g] & (miss_out | diff_zero[g]);
         wire regain = ~valid_q[g] & in_rise[g] & ~diff_zero[g] &
            (8'(good_q + 8'h01) >= counts_q.revalidation_count);
         always_ff @(posedge i_ref_clk or posedge i_reset) begin
            if (i_reset) begin
               miss_q <= 2'h0;
               good_q <= 8'h00;
               valid_bit_q <= 1'b0;
            end else begin
               if (in_rise[g]) begin
                  miss_q <= 2'h0;
               end else if (ref_tick && !miss_full) begin
                  miss_q <= 2'(miss_q + 2'h1);
               end
               if (lose || miss_out || diff_zero[g] || valid_q[g]) begin
                  good_q <= 8'h00;
               end else if (in_rise[g]) begin
                  good_q <= 8'(good_q + 8'h01);
               end
               if (lose) begin
                  valid_bit_q <= 1'b0;
               end else if (regain) begin
                  valid_bit_q <= 1'b1;
               end
            end
         end
         assign valid_q[g] = valid_bit_q;
         // blocked monitor neither drops validity nor raises events
         assign eff_valid[g] = valid_q[g] | ctrl_q.los_flag_block;
         assign loss_event[g] = lose & ~ctrl_q.los_flag_block;
      end
   endgenerate

   // ****************************************
   // priority choice
   // ****************************************
   logic [1:0] best_idx;
   logic [1:0] best_prio;
   logic any_valid;
   always_comb begin
      best_idx = 2'h0;
      best_prio = 2'h0;
      any_valid = 1'b0;
      for (int i = 0; i < NUM_INPUTS; i++) begin
         // strict greater keeps the lower index on a tie
         if (eff_valid[i] && (!any_valid || prio_q[2*i +: 2] > best_prio)) begin
            best_idx = 2'(i);
            best_prio = prio_q[2*i +: 2];
            any_valid = 1'b1;
         end
      end
   end

   // ****************************************
   // selection state machine
   // ****************************************
   ref_clock_monitor_select_pkg::sel_state_type state_q, state_d;
   logic [1:0] sel_q, sel_d;
   logic [7:0] hold_q;
   logic [15:0] presc_q;
   logic load_hold;
   wire sel_valid = eff_valid[sel_q];
   wire [1:0] sel_prio = prio_q[2*sel_q +: 2];
   wire better = any_valid & (best_prio > sel_prio) & (best_idx != sel_q);
   wire hold_run = (mode == ref_clock_monitor_select_pkg::MODE_AUTO_HOLD) &
      (state_q == ref_clock_monitor_select_pkg::ST_HOLDOVER);
   wire presc_tick = hold_run & vcxo_rise & (presc_q >= counts_q.holdoff_prescaler);
   wire expire = presc_tick & (hold_q == 8'h00);

   always_comb begin
      state_d = state_q;
      sel_d = sel_q;
      load_hold = 1'b0;
      case (mode)
         ref_clock_monitor_select_pkg::MODE_MANUAL: begin
            sel_d = ctrl_q.manual_select;
            state_d = sel_valid ? ref_clock_monitor_select_pkg::ST_LOCKED :
               ref_clock_monitor_select_pkg::ST_UNLOCKED;
         end
         ref_clock_monitor_select_pkg::MODE_SHORT_HOLD: begin
            sel_d = ctrl_q.manual_select;
            state_d = sel_valid ? ref_clock_monitor_select_pkg::ST_LOCKED :
               ref_clock_monitor_select_pkg::ST_HOLDOVER;
         end
         ref_clock_monitor_select_pkg::MODE_AUTO: begin
            if (!sel_valid) begin
               if (any_valid) begin
                  sel_d = best_idx;
                  state_d = ref_clock_monitor_select_pkg::ST_LOCKED;
               end else begin
                  state_d = ref_clock_monitor_select_pkg::ST_UNLOCKED;
               end
            end else begin
               state_d = ref_clock_monitor_select_pkg::ST_LOCKED;
               if (ctrl_q.revertive_enable && better) begin
                  sel_d = best_idx;
               end
            end
         end
         default: begin
            case (state_q)
               ref_clock_monitor_select_pkg::ST_HOLDOVER: begin
                  // revertive has no say until the countdown ends
                  if (expire) begin
                     if (sel_valid) begin
                        state_d = ref_clock_monitor_select_pkg::ST_LOCKED;
                     end else if (any_valid) begin
                        sel_d = best_idx;
                        state_d = ref_clock_monitor_select_pkg::ST_LOCKED;
                     end
                     // no valid input: stay in holdover, counter reloads
                  end
               end
               default: begin
                  if (!sel_valid) begin
                     state_d = ref_clock_monitor_select_pkg::ST_HOLDOVER;
                     load_hold = 1'b1;
                  end else begin
                     state_d = ref_clock_monitor_select_pkg::ST_LOCKED;
                     if (ctrl_q.revertive_enable && better) begin
                        sel_d = best_idx;
                     end
                  end
               end
            endcase
         end
      endcase
   end

   always_ff @(posedge i_ref_clk or posedge i_reset) begin
      if (i_reset) begin
         state_q <= ref_clock_monitor_select_pkg::ST_UNLOCKED;
         sel_q <= 2'h0;
      end else begin
         state_q <= state_d;
         sel_q <= sel_d;
      end
   end

   // ****************************************
   // hold-off prescaler and down-counter
   // ****************************************
   always_ff @(posedge i_ref_clk or posedge i_reset) begin
      if (i_reset) begin
         presc_q <= 16'h0000;
         hold_q <= 8'h00;
      end else begin
         if (!hold_run || presc_tick) begin
            presc_q <= 16'h0000;
         end else if (vcxo_rise) begin
            presc_q <= 16'(presc_q + 16'h0001);
         end
         if (load_hold || expire) begin
            hold_q <= counts_q.holdoff_start_value;
         end else if (presc_tick) begin
            hold_q <= 8'(hold_q - 8'h01);
         end
      end
   end

   // ****************************************
   // holdover word and outputs
   // ****************************************
   wire locked = (state_q == ref_clock_monitor_select_pkg::ST_LOCKED);
   always_ff @(posedge i_ref_clk or posedge i_reset) begin
      if (i_reset) begin
         o_holdover_word <= '0;
      end else if (locked) begin
         o_holdover_word <= i_freq_word;
      end
   end

   assign o_selected_input = sel_q;
   assign o_holdover = (state_q == ref_clock_monitor_select_pkg::ST_HOLDOVER);
   assign o_pll_lock_enable = locked;
   assign o_los_ref_divider_powerdown = ctrl_q.los_ref_divider_powerdown;

   // ****************************************
   // axi4-lite slave
   // ****************************************
   logic aw_hold_q, w_hold_q, bvalid_q, rvalid_q;
   logic [7:0] awaddr_q;
   logic [31:0] wdata_q, rdata_q;
   logic [3:0] wstrb_q;
   logic [1:0] bresp_q, rresp_q;
   logic sel_valid_q;

   function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[8*b +: 8] = new_v[8*b +: 8];
         end
      end
      return r;
   endfunction

   wire do_write = aw_hold_q & w_hold_q & ~bvalid_q;
   wire wr_ctrl = do_write & (awaddr_q == ref_clock_monitor_select_pkg::ADDR_CONTROL);
   wire wr_prio = do_write & (awaddr_q == ref_clock_monitor_select_pkg::ADDR_PRIORITY);
   wire wr_counts = do_write & (awaddr_q == ref_clock_monitor_select_pkg::ADDR_COUNTS);
   wire wr_loss = do_write & (awaddr_q == ref_clock_monitor_select_pkg::ADDR_LOSS);
   wire wr_status = do_write & (awaddr_q == ref_clock_monitor_select_pkg::ADDR_STATUS);
   wire wr_ok = wr_ctrl | wr_prio | wr_counts | wr_loss | wr_status;
   wire [31:0] ctrl_word = {25'h0, ctrl_q};
   wire [31:0] merged_ctrl = merge(ctrl_word, wdata_q, wstrb_q);
   wire [31:0] merged_prio = merge({24'h0, prio_q}, wdata_q, wstrb_q);
   wire [31:0] merged_counts = merge(counts_q, wdata_q, wstrb_q);
   wire [31:0] clr_mask = wstrb_q[0] ? wdata_q : 32'h0000_0000;
   wire ref_loss_event = sel_valid_q & ~sel_valid & (sel_q == sel_d) & ~ctrl_q.los_flag_block;

   wire [31:0] status_word = {23'h0, locked, sel_valid, o_holdover, sel_q, eff_valid};
   wire [31:0] loss_word = {27'h0, ref_loss_latched_q, loss_latched_q};
   wire rd_ctrl = (i_s_axi_araddr == ref_clock_monitor_select_pkg::ADDR_CONTROL);
   wire rd_prio = (i_s_axi_araddr == ref_clock_monitor_select_pkg::ADDR_PRIORITY);
   wire rd_counts = (i_s_axi_araddr == ref_clock_monitor_select_pkg::ADDR_COUNTS);
   wire rd_status = (i_s_axi_araddr == ref_clock_monitor_select_pkg::ADDR_STATUS);
   wire rd_loss = (i_s_axi_araddr == ref_clock_monitor_select_pkg::ADDR_LOSS);
   wire rd_ok = rd_ctrl | rd_prio | rd_counts | rd_status | rd_loss;
   wire [31:0] rd_mux = rd_ctrl ? ctrl_word : rd_prio ? {24'h0, prio_q} :
      rd_counts ? counts_q : rd_status ? status_word : rd_loss ? loss_word : 32'h0000_0000;
   wire rd_take = i_s_axi_arvalid & ~rvalid_q;

   assign o_s_axi_awready = ~aw_hold_q & ~bvalid_q;
   assign o_s_axi_wready = ~w_hold_q & ~bvalid_q;
   assign o_s_axi_bvalid = bvalid_q;
   assign o_s_axi_bresp = bresp_q;
   assign o_s_axi_arready = ~rvalid_q;
   assign o_s_axi_rvalid = rvalid_q;
   assign o_s_axi_rdata = rdata_q;
   assign o_s_axi_rresp = rresp_q;

   always_ff @(posedge i_ref_clk or posedge i_reset) begin
      if (i_reset) begin
         aw_hold_q <= 1'b0;
         w_hold_q <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
         bvalid_q <= 1'b0;
         bresp_q <= ref_clock_monitor_select_pkg::AXI_OKAY;
      end else begin
         if (i_s_axi_awvalid && o_s_axi_awready) begin
            aw_hold_q <= 1'b1;
            awaddr_q <= i_s_axi_awaddr;
         end else if (do_write) begin
            aw_hold_q <= 1'b0;
         end
         if (i_s_axi_wvalid && o_s_axi_wready) begin
            w_hold_q <= 1'b1;
            wdata_q <= i_s_axi_wdata;
            wstrb_q <= i_s_axi_wstrb;
         end else if (do_write) begin
            w_hold_q <= 1'b0;
         end
         if (do_write) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_ok ? ref_clock_monitor_select_pkg::AXI_OKAY :
               ref_clock_monitor_select_pkg::AXI_SLVERR;
         end else if (i_s_axi_bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_reset) begin
      if (i_reset) begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= ref_clock_monitor_select_pkg::AXI_OKAY;
      end else if (rd_take) begin
         rvalid_q <= 1'b1;
         rdata_q <= rd_mux;
         rresp_q <= rd_ok ? ref_clock_monitor_select_pkg::AXI_OKAY :
            ref_clock_monitor_select_pkg::AXI_SLVERR;
      end else if (i_s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_reset) begin
      if (i_reset) begin
         ctrl_q <= ref_clock_monitor_select_pkg::CONTROL_RESET;
         prio_q <= ref_clock_monitor_select_pkg::PRIORITY_RESET;
         counts_q <= ref_clock_monitor_select_pkg::COUNTS_RESET;
         loss_latched_q <= '0;
         ref_loss_latched_q <= 1'b0;
         sel_valid_q <= 1'b0;
      end else begin
         sel_valid_q <= sel_valid;
         if (wr_ctrl) begin
            ctrl_q <= merged_ctrl[ref_clock_monitor_select_pkg::CTRL_WIDTH-1:0];
         end
         if (wr_prio) begin
            prio_q <= merged_prio[7:0];
         end
         if (wr_counts) begin
            counts_q <= merged_counts;
         end
         // new event wins over a clear in the same cycle
         loss_latched_q <= loss_event |
            (loss_latched_q & ~(wr_loss ? clr_mask[NUM_INPUTS-1:0] : '0));
         // no valid reference means the latched loss cannot be cleared
         ref_loss_latched_q <= ref_loss_event | (ref_loss_latched_q & ~(wr_loss & sel_valid &
            clr_mask[ref_clock_monitor_select_pkg::LOSS_REF_BIT]));
      end
   end

endmodule

/* File: ref_clock_monitor_select_assertions.sv */
module ref_clock_monitor_select_checker #(
   parameter int FREQ_W = 24
) (
   input wire logic i_ref_clk,
   input wire logic i_reset,
   input wire logic i_s_axi_awvalid,
   input wire logic i_s_axi_wvalid,
   input wire logic i_s_axi_bready,
   input wire logic i_s_axi_arvalid,
   input wire logic i_s_axi_rready,
   input wire logic o_s_axi_awready,
   input wire logic o_s_axi_wready,
   input wire logic o_s_axi_bvalid,
   input wire logic o_s_axi_arready,
   input wire logic o_s_axi_rvalid,
   input wire logic [31:0] o_s_axi_rdata,
   input wire logic o_holdover,
   input wire logic o_pll_lock_enable,
   input wire logic [FREQ_W-1:0] o_holdover_word
);
   // ********
   // bus and holdover checks
   // ********
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (i_reset);
   bresp_hold_a: assert property (o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid)
      else $error("write response dropped before bready");
   rdata_hold_a: assert property (o_s_axi_rvalid && !i_s_axi_rready
      |=> o_s_axi_rvalid && $stable(o_s_axi_rdata)) else $error("read data not held");
   write_block_a: assert property (o_s_axi_bvalid |-> !o_s_axi_awready && !o_s_axi_wready)
      else $error("write taken while response pending");
   read_block_a: assert property (o_s_axi_rvalid |-> !o_s_axi_arready)
      else $error("read taken while data pending");
   read_answer_a: assert property (i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid)
      else $error("read answer late");
   write_answer_a: assert property (i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid
      && o_s_axi_wready |-> ##[1:2] o_s_axi_bvalid) else $error("write answer late");
   hold_unlock_a: assert property (
      o_holdover |-> !o_pll_lock_enable) else $error("locked during holdover");
   hold_word_a: assert property (
      $past(o_holdover) && o_holdover |-> $stable(o_holdover_word))
      else $error("holdover word moved");
endmodule

bind ref_clock_monitor_select ref_clock_monitor_select_checker #(.FREQ_W(FREQ_W)) u_chk (
   .i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_s_axi_awvalid(i_s_axi_awvalid),
   .i_s_axi_wvalid(i_s_axi_wvalid), .i_s_axi_bready(i_s_axi_bready),
   .i_s_axi_arvalid(i_s_axi_arvalid), .i_s_axi_rready(i_s_axi_rready),
   .o_s_axi_awready(o_s_axi_awready), .o_s_axi_wready(o_s_axi_wready),
   .o_s_axi_bvalid(o_s_axi_bvalid), .o_s_axi_arready(o_s_axi_arready),
   .o_s_axi_rvalid(o_s_axi_rvalid), .o_s_axi_rdata(o_s_axi_rdata),
   .o_holdover(o_holdover), .o_pll_lock_enable(o_pll_lock_enable),
   .o_holdover_word(o_holdover_word));

/* File: ref_source_model.sv */
module ref_source_model (
   input wire logic i_ref_clk,
   input wire logic [3:0] i_run,
   output logic [3:0] o_clk_in,
   output logic o_los_ref_div,
   output logic o_vcxo_div
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] phase_q = 3'h0;
   always @(posedge i_ref_clk) begin
      phase_q <= phase_q + 3'h1;
   end
   // divider set to the input rate, so no false loss
   assign o_los_ref_div = phase_q[2];
   assign o_vcxo_div = phase_q[1];
   // a stopped source leaves its pin static
   assign o_clk_in = i_run & {4{phase_q[2]}};
endmodule

/* File: ref_clock_monitor_select_tb.sv */
module ref_clock_monitor_select_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [3:0] run = 4'h0;
   logic [3:0] dz = 4'h0;
   logic [23:0] fw = 24'h0;
   logic [7:0] awaddr = 8'h0, araddr = 8'h0;
   logic [31:0] wdata = 32'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, hold, lock, pd, los_div, vcxo;
   logic [1:0] bresp, rresp, sel;
   logic [31:0] rdata;
   logic [23:0] hword;
   logic [3:0] clk_in;
   int err_total = 0;
   int checked = 0;
   int seed = 32'h9d1089d7;
   int prio[4];
   logic [23:0] hw_exp = 24'h0;
   always #4 clk = ~clk;
   always @(posedge clk) fw <= 24'($random(seed));
   // holdover word model: last frequency word seen while locked
   always @(posedge clk) if (lock) hw_exp <= fw;
   ref_source_model u_ref_source_model (.i_ref_clk(clk), .i_run(run), .o_clk_in(clk_in),
      .o_los_ref_div(los_div), .o_vcxo_div(vcxo));
   ref_clock_monitor_select u_ref_clock_monitor_select (.i_ref_clk(clk), .i_reset(rst),
      .i_clk_in(clk_in), .i_diff_zero(dz), .i_los_ref_div(los_div), .i_vcxo_div(vcxo),
      .i_freq_word(fw), .o_selected_input(sel), .o_holdover(hold), .o_pll_lock_enable(lock),
      .o_holdover_word(hword), .o_los_ref_divider_powerdown(pd), .i_s_axi_awaddr(awaddr),
      .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready), .i_s_axi_wdata(wdata),
      .i_s_axi_wstrb(4'hF), .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready),
      .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready),
      .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready),
      .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid),
      .i_s_axi_rready(rready));
   // ********
   // bus tasks and model
   // ********
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // response taken at the edge where valid is first seen; one idle edge after
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] er = 2'h0);
      bit done = 0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!done) begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         done = bvalid;
      end
      bready <= 1'b0;
      cmp({30'h0, bresp}, {30'h0, er});
      @(posedge clk);
   endtask
   task automatic rd_cmp(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      bit done = 0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!done) begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
         done = rvalid;
      end
      rready <= 1'b0;
      cmp(rdata, e);
      cmp({30'h0, rresp}, {30'h0, er});
      @(posedge clk);
   endtask
   function automatic logic [1:0] best(input logic [3:0] m);
      int b = -1;
      for (int i = 3; i >= 0; i--) begin
         if (m[i] && (b < 0 || prio[i] >= prio[b])) b = i;
      end
      return 2'(b);
   endfunction
   task automatic expect_state(input logic [1:0] s, input logic h, input logic k,
      input logic [3:0] m);
      cmp({29'h0, hold, lock, sel}, {29'h0, h, k, s});
      cmp({8'h0, hword}, {8'h0, hw_exp});
      rd_cmp(ref_clock_monitor_select_pkg::ADDR_STATUS, {23'h0, k, m[s], h, s, m}, 2'h0);
   endtask
   task automatic summarize();
      $display("checked %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      summarize();
   end
   // ********
   // scenarios
   // ********
   initial begin
      logic [31:0] d;
      logic [3:0] alive = 4'hF;
      logic [1:0] cur = 2'h0;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      cmp({30'h0, pd, sel == 2'h0}, 32'h3);
      rd_cmp(ref_clock_monitor_select_pkg::ADDR_CONTROL, 32'h40, 2'h0);
      rd_cmp(ref_clock_monitor_select_pkg::ADDR_COUNTS, 32'h0, 2'h0);
      rd_cmp(8'h14, 32'h0, ref_clock_monitor_select_pkg::AXI_SLVERR);
      axi_wr(8'h14, 32'h0, ref_clock_monitor_select_pkg::AXI_SLVERR);
      $display("test reset done");
      d = $random(seed);
      for (int i = 0; i < 4; i++) prio[i] = d[2*i +: 2];
      axi_wr(ref_clock_monitor_select_pkg::ADDR_PRIORITY, {24'h0, d[7:0]});
      axi_wr(ref_clock_monitor_select_pkg::ADDR_COUNTS, 32'h0000_0302);
      axi_wr(ref_clock_monitor_select_pkg::ADDR_CONTROL, 32'h0);
      run <= 4'hF;
      repeat (120) @(posedge clk);
      expect_state(2'h0, 1'b0, 1'b1, 4'hF);
      axi_wr(ref_clock_monitor_select_pkg::ADDR_CONTROL, 32'h1);
      for (int k = 0; k < 4; k++) begin
         run[cur] <= 1'b0;
         alive[cur] = 1'b0;
         if (alive != 4'h0) cur = best(alive);
         repeat (120) @(posedge clk);
         expect_state(cur, 1'b0, alive != 4'h0, alive);
      end
      $display("test fail-over done");
      run <= 4'hF;
      repeat (120) @(posedge clk);
      axi_wr(ref_clock_monitor_select_pkg::ADDR_CONTROL, 32'h0A);
      axi_wr(ref_clock_monitor_select_pkg::ADDR_LOSS, 32'h1F);
      rd_cmp(ref_clock_monitor_select_pkg::ADDR_LOSS, 32'h0, 2'h0);
      expect_state(2'h2, 1'b0, 1'b1, 4'hF);
      dz[2] <= 1'b1;
      repeat (40) @(posedge clk);
      expect_state(2'h2, 1'b1, 1'b0, 4'hB);
      rd_cmp(ref_clock_monitor_select_pkg::ADDR_LOSS, 32'h14, 2'h0);
      dz[2] <= 1'b0;
      repeat (120) @(posedge clk);
      expect_state(2'h2, 1'b0, 1'b1, 4'hF);
      $display("test short holdover done");
      axi_wr(ref_clock_monitor_select_pkg::ADDR_CONTROL, 32'h0B);
      run[2] <= 1'b0;
      for (int i = 0; i < 200 && hold !== 1'b1; i++) @(posedge clk);
      expect_state(2'h2, 1'b1, 1'b0, 4'hB);
      repeat (120) @(posedge clk);
      expect_state(best(4'hB), 1'b0, 1'b1, 4'hB);
      $display("test hold-off done");
      axi_wr(ref_clock_monitor_select_pkg::ADDR_CONTROL, 32'h1B);
      run <= 4'hF;
      repeat (120) @(posedge clk);
      cur = (prio[best(4'hF)] > prio[best(4'hB)]) ? best(4'hF) : best(4'hB);
      expect_state(cur, 1'b0, 1'b1, 4'hF);
      axi_wr(ref_clock_monitor_select_pkg::ADDR_CONTROL, 32'h28);
      axi_wr(ref_clock_monitor_select_pkg::ADDR_LOSS, 32'h1F);
      run <= 4'h0;
      repeat (120) @(posedge clk);
      rd_cmp(ref_clock_monitor_select_pkg::ADDR_LOSS, 32'h0, 2'h0);
      expect_state(2'h2, 1'b0, 1'b1, 4'hF);
      $display("test revertive and block done");
      summarize();
   end
endmodule
